// ### design/ppt_err_regs.sv
// Per-port parity and time-out error control/status register bank.
// Assumes core event pulses on clk_i and an Avalon-MM master on clk_i.
`timescale 1ns/1ps

// How it works
// RULE_01: Parity report field bits 1:0, reset 2
// RULE_02: Parity report codes: none, cor, nonfatal, fatal
// RULE_03: Parity counter counts each detected error
// RULE_04: Counter saturates at FF, never wraps
// RULE_05: Reading counter returns count and clears it
// RULE_06: Time-out enable bit 0, reset 1
// RULE_07: Posted discard sets status bit 0, W1C
// RULE_08: Non-posted discard sets status bit 1
// RULE_09: Completion discard sets status bit 2
// RULE_10: Insertion discard sets status bit 3
// RULE_11: Time-out reported only on zero-to-one
// RULE_12: Posted report field bits 1:0, reset 2
// RULE_13: Non-posted report field bits 3:2, reset 0
// RULE_14: Completion report field bits 5:4, reset 0
// RULE_15: Time-out report codes match parity codes
// RULE_16: Parity status flag bit 0, W1C
// RULE_17: Insertion report field bits 7:6, reset 2
// RULE_18: Parity disable stops all parity flagging
// RULE_19: Queue simultaneous reports, lose none
module ppt_err_regs
  import ppt_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Avalon-MM slave
  input  wire logic [11:0]       avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Core events
  input  wire logic              parity_error_i,
  input  wire logic [PPT_NQ-1:0] queue_discard_i,
  output logic                   timeout_enable_o,
  output logic                   parity_check_off_o,
  // Error messages to the root
  output logic                   msg_valid_o,
  output ppt_sev_t               msg_severity_o,
  output logic [2:0]             msg_source_o,
  input  wire logic              msg_ready_i,
  // Interrupt
  output logic                   irq_o
);

  logic                  ack;
  logic                  rd_take;
  logic                  wr_take;
  logic                  wr_lo;
  logic [31:0]           next_rdata;
  logic                  par_dis;
  logic                  par_flag;
  logic [1:0]            par_rpt;
  logic [PPT_CNT_W-1:0]  par_cnt;
  logic                  to_en;
  logic [PPT_NQ-1:0]     to_flags;
  logic [7:0]            to_rpt;
  logic [PPT_NSRC-1:0]   irq_sts;
  logic [PPT_NSRC-1:0]   irq_mask;
  logic                  par_seen;
  logic [PPT_NQ-1:0]     to_seen;
  logic                  par_rise;
  logic [PPT_NQ-1:0]     to_rise;
  logic [PPT_NSRC-1:0]   rise;
  logic [2*PPT_NSRC-1:0] sev_sel;
  logic [PPT_NSRC-1:0]   rep_req;
  logic                  cnt_clr;

  // Write-one-to-clear update where a new event wins over the clear
  function automatic logic [PPT_NSRC-1:0] w1c(
    input logic [PPT_NSRC-1:0] cur,
    input logic [PPT_NSRC-1:0] set,
    input logic [PPT_NSRC-1:0] clr
  );
    w1c = (cur & ~clr) | set;
  endfunction : w1c

  // Write strobe for a given register, low byte lane only
  function automatic logic wr_hit(input logic [11:0] off);
    wr_hit = wr_take && wr_lo && (avs_address == off);
  endfunction : wr_hit

  // Bus handshake: every access waits exactly one cycle
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign rd_take         = avs_read && !ack;
  assign wr_take         = avs_write && !ack;
  assign wr_lo           = avs_byteenable[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  // Event qualification
  assign par_seen = parity_error_i && !par_dis; // RULE_18
  assign to_seen  = queue_discard_i & {PPT_NQ{to_en}}; // RULE_06
  assign par_rise = par_seen && !par_flag; // RULE_01
  assign to_rise  = to_seen & ~to_flags; // RULE_11
  assign rise     = {to_rise, par_rise};

  // Severity per source: parity, posted, non-posted, completion, insertion
  assign sev_sel  = {to_rpt, par_rpt}; // RULE_15
  always_comb begin
    for (int i = 0; i < PPT_NSRC; i++) begin
      rep_req[i] = rise[i] && (sev_sel[2*i +: 2] != PPT_SEV_NONE); // RULE_02
    end
  end

  // Control registers written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      par_dis <= PPT_RST_PAR_DIS;
      par_rpt <= PPT_RST_PAR_RPT; // RULE_01
      to_en   <= PPT_RST_TO_EN; // RULE_06
      to_rpt  <= PPT_RST_TO_RPT; // RULE_12
    end else begin
      if (wr_hit(PPT_OFF_PAR_DIS)) begin
        par_dis <= avs_writedata[PPT_POS_PAR_DIS];
      end
      if (wr_hit(PPT_OFF_PAR_RPT)) begin
        par_rpt <= avs_writedata[1:0];
      end
      if (wr_hit(PPT_OFF_TO_EN)) begin
        to_en <= avs_writedata[PPT_POS_TO_EN];
      end
      if (wr_hit(PPT_OFF_TO_RPT)) begin
        to_rpt <= avs_writedata[7:0]; // RULE_13 RULE_14 RULE_17
      end
    end
  end

  // Parity status flag, write one to clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      par_flag <= 1'b0;
    end else begin
      par_flag <= par_seen ||
        (par_flag && !(wr_hit(PPT_OFF_PAR_STS) &&
                       avs_writedata[PPT_POS_PAR_FLAG])); // RULE_16
    end
  end

  // Time-out status flags, one per queue
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_flags <= '0;
    end else begin
      to_flags <= PPT_NQ'(w1c(PPT_NSRC'(to_flags), PPT_NSRC'(to_seen),
        wr_hit(PPT_OFF_TO_STS) ? PPT_NSRC'(avs_writedata[PPT_NQ-1:0])
                               : '0)); // RULE_07 RULE_08 RULE_09 RULE_10
    end
  end

  // Interrupt status and mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sts  <= '0;
      irq_mask <= '0;
    end else begin
      irq_sts <= w1c(irq_sts, rise,
        wr_hit(PPT_OFF_IRQ_STS) ? avs_writedata[PPT_NSRC-1:0] : '0);
      if (wr_hit(PPT_OFF_IRQ_MASK)) begin
        irq_mask <= avs_writedata[PPT_NSRC-1:0];
      end
    end
  end

  assign irq_o = |(irq_sts & irq_mask);

  // Parity error counter, cleared by the accepted read
  assign cnt_clr = rd_take && (avs_address == PPT_OFF_PAR_CNT); // RULE_05

  ppt_sat_counter #(
    .WIDTH   (PPT_CNT_W)
  ) u_par_cnt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .inc_i   (par_seen), // RULE_03
    .clr_i   (cnt_clr),
    .count_o (par_cnt)
  );

  // Report queue towards the root
  ppt_msg_sched #(
    .NSRC    (PPT_NSRC)
  ) u_sched (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .req_i   (rep_req), // RULE_19
    .sev_i   (sev_sel),
    .ready_i (msg_ready_i),
    .valid_o (msg_valid_o),
    .sev_o   (msg_severity_o),
    .src_o   (msg_source_o)
  );

  // Read data mux; unmapped words read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (avs_address)
      PPT_OFF_PAR_DIS:  next_rdata[PPT_POS_PAR_DIS] = par_dis;
      PPT_OFF_PAR_STS:  next_rdata[PPT_POS_PAR_FLAG] = par_flag;
      PPT_OFF_PAR_RPT:  next_rdata[1:0] = par_rpt;
      PPT_OFF_PAR_CNT:  next_rdata[PPT_CNT_W-1:0] = par_cnt; // RULE_05
      PPT_OFF_TO_EN:    next_rdata[PPT_POS_TO_EN] = to_en;
      PPT_OFF_TO_STS:   next_rdata[PPT_NQ-1:0] = to_flags;
      PPT_OFF_TO_RPT:   next_rdata[7:0] = to_rpt;
      PPT_OFF_IRQ_STS:  next_rdata[PPT_NSRC-1:0] = irq_sts;
      PPT_OFF_IRQ_MASK: next_rdata[PPT_NSRC-1:0] = irq_mask;
      default:          next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data captured when the read is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata <= next_rdata;
    end
  end

  // Pins to the core
  assign timeout_enable_o   = to_en;
  assign parity_check_off_o = par_dis;

  // Checks
  sequence s_cnt_read;
    rd_take && avs_address == PPT_OFF_PAR_CNT && !par_seen;
  endsequence

  a_count_clear: assert property ( // RULE_05
    @(posedge clk_i) disable iff (rst_i)
    s_cnt_read |=> par_cnt == PPT_RST_CNT && avs_readdata[7:0] ==
      $past(par_cnt))
    else $error("counter read did not clear or return the count");

  a_count_step: assert property ( // RULE_03
    @(posedge clk_i) disable iff (rst_i)
    par_seen && !cnt_clr && par_cnt != PPT_CNT_MAX |=>
      par_cnt == $past(par_cnt) + 8'h01)
    else $error("counter missed an error");

  a_parity_off: assert property ( // RULE_18
    @(posedge clk_i) disable iff (rst_i)
    par_dis && !par_flag |=> !par_flag)
    else $error("parity flagged while checking disabled");

  a_parity_report: assert property ( // RULE_01
    @(posedge clk_i) disable iff (rst_i)
    par_flag |-> !rep_req[0])
    else $error("parity report with flag already set");

  a_to_set: assert property ( // RULE_07 RULE_08 RULE_09 RULE_10
    @(posedge clk_i) disable iff (rst_i)
    |to_seen |=> (to_flags & $past(to_seen)) == $past(to_seen))
    else $error("time-out status bit not set");

  a_to_once: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    (to_flags[PPT_POS_TO_P] && to_seen[PPT_POS_TO_P]) |-> !rep_req[1])
    else $error("repeated time-out report");

  a_reset_vals: assert property ( // RULE_12 RULE_13 RULE_14 RULE_17
    @(posedge clk_i)
    $fell(rst_i) |-> to_rpt == 8'h82 && par_rpt == 2'h2 && to_en &&
      !par_dis && par_cnt == 8'h00)
    else $error("wrong values after reset");

  a_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(rise & irq_mask)) &&
      !(wr_take && wr_lo && avs_address == PPT_OFF_IRQ_MASK) |=> irq_o)
    else $error("interrupt not raised");

  a_bus_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    avs_waitrequest |=> !avs_waitrequest)
    else $error("wait request longer than one cycle");

  // Clear writes to the status flags, seen at the accepting edge
  sequence s_par_clr_write;
    wr_take && wr_lo && avs_address == PPT_OFF_PAR_STS &&
      avs_writedata[PPT_POS_PAR_FLAG];
  endsequence

  sequence s_to_clr_write;
    wr_take && wr_lo && avs_address == PPT_OFF_TO_STS;
  endsequence

  // Parity rise with a live report field, and source 0 at the head
  sequence s_par_report;
    par_rise && par_rpt != PPT_SEV_NONE;
  endsequence

  sequence s_src0_shown;
    msg_valid_o && msg_source_o == 3'h0;
  endsequence

  // A detected error beats a clear written in the same cycle
  a_par_set_wins: assert property ( // RULE_16
    @(posedge clk_i) disable iff (rst_i)
    s_par_clr_write ##0 par_seen |=> par_flag)
    else $error("parity flag lost to a clear");

  a_par_clear: assert property ( // RULE_16
    @(posedge clk_i) disable iff (rst_i)
    s_par_clr_write ##0 !par_seen |=> !par_flag)
    else $error("parity flag not cleared");

  a_to_clear: assert property ( // RULE_07
    @(posedge clk_i) disable iff (rst_i)
    s_to_clr_write ##0 (avs_writedata[PPT_POS_TO_P] &&
      !to_seen[PPT_POS_TO_P]) |=> !to_flags[PPT_POS_TO_P])
    else $error("posted time-out flag not cleared");

  // Disabled time-outs raise no new flag
  a_to_off: assert property ( // RULE_06
    @(posedge clk_i) disable iff (rst_i)
    !to_en |=> (to_flags & ~$past(to_flags)) == 4'h0)
    else $error("time-out flagged while disabled");

  // Disabled checking leaves the count alone
  a_cnt_off: assert property ( // RULE_18
    @(posedge clk_i) disable iff (rst_i)
    par_dis && !cnt_clr |=> par_cnt == $past(par_cnt))
    else $error("parity counted while checking disabled");

  // A parity report reaches the queue head with the field's code
  a_par_msg: assert property ( // RULE_01 RULE_02
    @(posedge clk_i) disable iff (rst_i)
    s_par_report |=> s_src0_shown ##0 msg_severity_o == $past(par_rpt))
    else $error("parity report not queued with its code");

  // Any report request is pending one cycle later
  a_report_queued: assert property ( // RULE_19
    @(posedge clk_i) disable iff (rst_i)
    (|rep_req) |=> msg_valid_o)
    else $error("report request not queued");

  // Read data stand until the next read is taken
  a_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_take |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  // A report field write lands at the accepting edge
  a_rpt_write: assert property ( // RULE_01
    @(posedge clk_i) disable iff (rst_i)
    wr_take && wr_lo && avs_address == PPT_OFF_PAR_RPT |=>
      par_rpt == $past(avs_writedata[1:0]))
    else $error("report field write lost");

endmodule : ppt_err_regs

// ### design/ppt_msg_sched.sv
// Error message scheduler: one pending slot per report source.
// Assumes the upstream sink takes a message on valid and ready high.
`timescale 1ns/1ps
module ppt_msg_sched
  import ppt_pkg::*;
#(
  parameter int NSRC = PPT_NSRC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [NSRC-1:0]   req_i,
  input  wire logic [2*NSRC-1:0] sev_i,
  input  wire logic              ready_i,
  output logic                   valid_o,
  output ppt_sev_t               sev_o,
  output logic [$clog2(NSRC)-1:0] src_o
);

  logic [NSRC-1:0]   pending;
  logic [2*NSRC-1:0] sev_held;
  logic [NSRC-1:0]   take;

  // Lowest pending source goes first
  function automatic logic [$clog2(NSRC)-1:0] pick(input logic [NSRC-1:0] p);
    pick = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (p[i]) pick = ($clog2(NSRC))'(i);
    end
  endfunction : pick

  assign valid_o = |pending;
  assign src_o   = pick(pending);
  assign sev_o   = ppt_sev_t'(sev_held[2*src_o +: 2]);
  assign take    = (valid_o && ready_i) ? (NSRC'(1) << src_o) : '0;

  // Pending slots; a new request beats the hand-off of the same slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending  <= '0;
      sev_held <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (req_i[i]) begin
          pending[i]        <= 1'b1; // RULE_19
          sev_held[2*i +: 2] <= sev_i[2*i +: 2];
        end else if (take[i]) begin
          pending[i] <= 1'b0;
        end
      end
    end
  end

  a_msg_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_19
    valid_o && !ready_i |=> valid_o)
    else $error("message dropped before it was taken");

  a_msg_code: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    valid_o |-> sev_o != PPT_SEV_NONE)
    else $error("message sent with no severity");

endmodule : ppt_msg_sched

// ### design/ppt_pkg.sv
// Package for the port parity and time-out error register bank.
// Assumes a single core clock and a byte-addressed Avalon-MM slave port.
package ppt_pkg;

  // Register byte offsets
  localparam logic [11:0] PPT_OFF_PAR_DIS     = 12'h740;
  localparam logic [11:0] PPT_OFF_PAR_STS     = 12'h744;
  localparam logic [11:0] PPT_OFF_PAR_RPT     = 12'h748;
  localparam logic [11:0] PPT_OFF_PAR_CNT     = 12'h74C;
  localparam logic [11:0] PPT_OFF_TO_EN       = 12'h750;
  localparam logic [11:0] PPT_OFF_TO_STS      = 12'h754;
  localparam logic [11:0] PPT_OFF_TO_RPT      = 12'h758;
  localparam logic [11:0] PPT_OFF_IRQ_STS     = 12'h770;
  localparam logic [11:0] PPT_OFF_IRQ_MASK    = 12'h774;

  // Field positions
  localparam int PPT_POS_PAR_DIS  = 0;
  localparam int PPT_POS_PAR_FLAG = 0;
  localparam int PPT_POS_TO_EN    = 0;
  localparam int PPT_POS_TO_P     = 0;
  localparam int PPT_POS_TO_NP    = 1;
  localparam int PPT_POS_TO_CPL   = 2;
  localparam int PPT_POS_TO_INS   = 3;

  // Widths
  localparam int PPT_CNT_W   = 8;
  localparam int PPT_NQ      = 4;
  localparam int PPT_NSRC    = 5;

  // Reset values and counter maximum
  localparam logic [1:0] PPT_RST_PAR_RPT  = 2'h2;
  localparam logic [7:0] PPT_RST_TO_RPT   = 8'h82;
  localparam logic       PPT_RST_TO_EN    = 1'h1;
  localparam logic       PPT_RST_PAR_DIS  = 1'h0;
  localparam logic [7:0] PPT_RST_CNT      = 8'h00;
  localparam logic [7:0] PPT_CNT_MAX      = 8'hFF;

  // Report severity encoding
  typedef enum logic [1:0] {
    PPT_SEV_NONE     = 2'h0,
    PPT_SEV_CORR     = 2'h1,
    PPT_SEV_NONFATAL = 2'h2,
    PPT_SEV_FATAL    = 2'h3
  } ppt_sev_t;

endpackage : ppt_pkg

// ### design/ppt_sat_counter.sv
// Saturating event counter with clear.
// Assumes inc_i and clr_i come from logic on clk_i.
`timescale 1ns/1ps
module ppt_sat_counter
  import ppt_pkg::*;
#(
  parameter int WIDTH = PPT_CNT_W
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             inc_i,
  input  wire logic             clr_i,
  output logic      [WIDTH-1:0] count_o
);

  logic [WIDTH-1:0] next_count;

  // Clear drops the old value; an event in the same cycle still counts
  always_comb begin
    if (clr_i) begin
      next_count = inc_i ? WIDTH'(1) : '0;
    end else if (inc_i && !(&count_o)) begin
      next_count = count_o + WIDTH'(1); // RULE_03
    end else begin
      next_count = count_o; // RULE_04
    end
  end

  // Count register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= '0;
    end else begin
      count_o <= next_count;
    end
  end

  a_count_saturate: assert property ( // RULE_04
    @(posedge clk_i) disable iff (rst_i)
    (&count_o) && inc_i && !clr_i |=> (&count_o))
    else $error("counter left its maximum");

endmodule : ppt_sat_counter

// ### testbench/ppt_root_model.sv
// Root-side sink model that takes error messages from the register bank.
// Assumes a message is taken when valid and ready are high at an edge.
`timescale 1ns/1ps
module ppt_root_model
  import ppt_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       msg_valid_i,
  input  wire ppt_sev_t   msg_severity_i,
  input  wire logic [2:0] msg_source_i,
  input  wire logic       stall_i,
  output logic            msg_ready_o
);
  logic [2:0] log_src [256];
  logic [1:0] log_sev [256];
  int         n_got;

  // Ready drops while the bench stalls the root, so messages back up
  assign msg_ready_o = !stall_i;

  // Log every message taken, in arrival order
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      n_got <= 0;
    end else if (msg_valid_i && msg_ready_o) begin
      log_src[n_got[7:0]] <= msg_source_i;
      log_sev[n_got[7:0]] <= msg_severity_i;
      n_got <= n_got + 1;
    end
  end
endmodule : ppt_root_model

// ### testbench/tb_top.sv
// Self-checking bench for the parity and time-out error register bank.
// Assumes the root sink model on the message port and a 100 MHz clock.
`timescale 1ns/1ps
module tb_top;
  logic        clk_i;
  logic        rst_i;
  logic [11:0] addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic        perr;
  logic [3:0]  disc;
  logic        to_en;
  logic        par_off;
  logic        mvalid;
  ppt_pkg::ppt_sev_t msev;
  logic [2:0]  msrc;
  logic        mready;
  logic        irq;
  logic        stall;
  logic [31:0] q;
  int          n_errors;
  int          compares;
  int          n_exp;
  localparam logic [11:0] reg_addr [10] = '{12'h740, 12'h744, 12'h748,
    12'h74C, 12'h750, 12'h754, 12'h758, 12'h770, 12'h774, 12'h7F0};
  localparam logic [31:0] reg_rst [10] = '{32'h0, 32'h0, 32'h2, 32'h0,
    32'h1, 32'h0, 32'h82, 32'h0, 32'h0, 32'h0};

  // Core clock, 10 ns period
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ppt_err_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .parity_error_i(perr), .queue_discard_i(disc),
    .timeout_enable_o(to_en), .parity_check_off_o(par_off),
    .msg_valid_o(mvalid), .msg_severity_o(msev), .msg_source_o(msrc),
    .msg_ready_i(mready), .irq_o(irq));

  ppt_root_model i_root (.clk_i(clk_i), .rst_i(rst_i), .msg_valid_i(mvalid),
    .msg_severity_i(msev), .msg_source_i(msrc), .stall_i(stall),
    .msg_ready_o(mready));

  task automatic test_done;
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= d;
    be    <= b;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0) begin
      chk("bus wait", 0, 1);
      test_done();
    end
  endtask : bus

  task automatic wrr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wrr

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk($sformatf("reg %h", a), e, q);
  endtask : rdc

  // One-cycle event pulses
  task automatic pulse(input logic p, input logic [3:0] d);
    @(posedge clk_i);
    perr <= p;
    disc <= d;
    @(posedge clk_i);
    perr <= 1'b0;
    disc <= 4'h0;
  endtask : pulse

  // Wait for the next message at the root and compare it
  task automatic exp_msg(input logic [2:0] s, input logic [1:0] v);
    int n;
    n = 0;
    while (i_root.n_got <= n_exp && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (i_root.n_got <= n_exp) begin
      chk("msg timeout", 0, 1);
      test_done();
    end
    chk("msg source", {29'h0, s}, {29'h0, i_root.log_src[n_exp[7:0]]});
    chk("msg severity", {30'h0, v}, {30'h0, i_root.log_sev[n_exp[7:0]]});
    n_exp++;
  endtask : exp_msg

  task automatic no_msg;
    repeat (8) @(posedge clk_i);
    chk("msg count", n_exp, i_root.n_got);
  endtask : no_msg

  // Main sequence
  initial begin
    rst_i = 1'b1;
    addr = 12'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    be = 4'h0;
    perr = 1'b0;
    disc = 4'h0;
    stall = 1'b0;
    n_errors = 0;
    compares = 0;
    n_exp = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("timeout enable out", 1, to_en);
    for (int i = 0; i < 10; i++) begin
      rdc(reg_addr[i], reg_rst[i]);
    end
    pulse(1'b1, 4'h0);
    exp_msg(3'h0, 2'h2);
    rdc(12'h744, 32'h1);
    pulse(1'b1, 4'h0);
    no_msg();
    rdc(12'h74C, 32'h2);
    rdc(12'h74C, 32'h0);
    wrr(12'h744, 32'h1);
    rdc(12'h744, 32'h0);
    bus(1'b1, 12'h748, 32'h3, 4'h0);
    rdc(12'h748, 32'h2);
    wrr(12'h748, 32'hFFFFFFFF);
    rdc(12'h748, 32'h3);
    for (int c = 0; c < 4; c++) begin
      wrr(12'h748, c);
      pulse(1'b1, 4'h0);
      if (c == 0) no_msg();
      else exp_msg(3'h0, c[1:0]);
      wrr(12'h744, 32'h1);
    end
    wrr(12'h748, 32'h0);
    bus(1'b0, 12'h74C, 32'h0, 4'hF);
    repeat (260) pulse(1'b1, 4'h0);
    rdc(12'h74C, 32'hFF);
    wrr(12'h744, 32'h1);
    wrr(12'h740, 32'h1);
    chk("parity check off", 1, par_off);
    wrr(12'h748, 32'h3);
    pulse(1'b1, 4'h0);
    no_msg();
    rdc(12'h744, 32'h0);
    rdc(12'h74C, 32'h0);
    wrr(12'h740, 32'h0);
    for (int k = 0; k < 16; k++) begin
      wrr(12'h758, (k % 4) << (2 * (k / 4)));
      pulse(1'b0, 4'h1 << (k / 4));
      rdc(12'h754, 32'h1 << (k / 4));
      if (k % 4 == 0) no_msg();
      else exp_msg(3'(k / 4 + 1), 2'(k % 4));
      pulse(1'b0, 4'h1 << (k / 4));
      no_msg();
      wrr(12'h754, 32'h1 << (k / 4));
      rdc(12'h754, 32'h0);
    end
    wrr(12'h750, 32'h0);
    chk("timeout enable out", 0, to_en);
    pulse(1'b0, 4'hF);
    rdc(12'h754, 32'h0);
    wrr(12'h750, 32'h1);
    wrr(12'h758, 32'hFF);
    stall <= 1'b1;
    pulse(1'b1, 4'hF);
    repeat (4) @(posedge clk_i);
    chk("msg valid held", 1, mvalid);
    stall <= 1'b0;
    for (int s = 0; s < 5; s++) begin
      exp_msg(3'(s), 2'h3);
    end
    wrr(12'h758, 32'h0);
    wrr(12'h748, 32'h0);
    wrr(12'h754, 32'hF);
    wrr(12'h744, 32'h1);
    wrr(12'h770, 32'h1F);
    rdc(12'h770, 32'h0);
    chk("irq cleared", 0, irq);
    wrr(12'h774, 32'h1);
    pulse(1'b1, 4'h0);
    repeat (2) @(posedge clk_i);
    chk("irq raised", 1, irq);
    rdc(12'h770, 32'h1);
    wrr(12'h774, 32'h0);
    chk("irq masked", 0, irq);
    wrr(12'h774, 32'h1);
    wrr(12'h770, 32'h1);
    chk("irq after clear", 0, irq);
    // Error pulse lands on the clear's accepting edge: the set wins
    fork
      wrr(12'h744, 32'h1);
      pulse(1'b1, 4'h0);
    join
    rdc(12'h744, 32'h1);
    test_done();
  end
endmodule : tb_top
